// *** common/ecb_pkg.sv ***
// event counter bank shared constants and types
package ecb_pkg;

  // ------------------------------------------------------------
  // sizes and limits
  // ------------------------------------------------------------
  localparam int          ECB_NUM_COUNTERS = 256;
  localparam int          ECB_IDX_W        = 8;
  localparam int          ECB_VAL_W        = 16;
  localparam logic [15:0] ECB_MAX_VAL      = 16'h7FFF;
  localparam logic [15:0] ECB_MIN_VAL      = 16'h8000;
  localparam logic [15:0] ECB_ZERO_VAL     = 16'h0000;
  localparam logic [15:0] ECB_RESET_VAL    = 16'h0000;
  localparam logic [7:0]  ECB_IDX_ZERO     = 8'h00;
  localparam logic [7:0]  ECB_IDX_LAST     = 8'hFF;

  // ------------------------------------------------------------
  // counter instruction types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ECB_CLS_UP_COUNTER_TYPE,
    ECB_CLS_DOWN_COUNTER_TYPE,
    ECB_CLS_UP_DOWN_COUNTER_TYPE,
    ECB_STD_UP_COUNTER_TYPE,
    ECB_STD_DOWN_COUNTER_TYPE,
    ECB_STD_UP_DOWN_COUNTER_TYPE
  } ecb_type_t;

endpackage

// *** verilog/ecb_bank.sv ***
// event counter bank: 256 numbered 16-bit signed counters
`timescale 1ns/1ps

module ecb_bank
  import ecb_pkg::*;
#(
  parameter int NUM_COUNTERS = ECB_NUM_COUNTERS
) (
  // clock and reset
  input  wire logic                 mclk,
  input  wire logic                 nrst,
  // evaluation request from the controlling program
  input  wire logic                 exec,
  input  wire logic [ECB_IDX_W-1:0] counter_num,
  input  wire ecb_type_t            counter_type,
  input  wire logic                 count_up_input,
  input  wire logic                 count_down_input,
  input  wire logic                 reset_input,
  input  wire logic                 load_preset_input,
  input  wire logic [ECB_VAL_W-1:0] preset_value,
  // reset instruction, independent of evaluation
  input  wire logic                 reset_cmd,
  input  wire logic [ECB_IDX_W-1:0] reset_cmd_num,
  // first scan and retention selection
  input  wire logic                 first_scan,
  input  wire logic                 retentive_all,
  // readback by counter number
  input  wire logic [ECB_IDX_W-1:0] read_num,
  output logic [ECB_VAL_W-1:0]      read_value,
  output logic                      read_bit,
  // results of the last evaluation
  output logic                      done,
  output logic [ECB_VAL_W-1:0]      current_value,
  output logic                      counter_bit,
  output logic                      up_reached_output,
  output logic                      down_reached_output,
  // first-scan sweep in progress, evaluations held off
  output logic                      busy
);

  // ------------------------------------------------------------
  // timing at the ports
  // ------------------------------------------------------------
  // an evaluation is taken at an edge with exec high and busy low; done
  // pulses one cycle later and the result outputs hold until the next one.
  // exec while busy is dropped with no done, so the controller must wait
  // for busy to fall after a first scan before it evaluates again.
  // a reset instruction is taken at any edge outside a sweep; when it names
  // the counter being evaluated in the same cycle the evaluation wins.
  // readback is registered: read_value and read_bit show the array one
  // cycle after read_num, as it stood at that edge.
  // the value array has no reset, so a counter reads back unknown until a
  // clearing first scan, a reset instruction or an evaluation that resets or
  // loads it; scan once after power-up.

  // ------------------------------------------------------------
  // counter types at a glance
  // ------------------------------------------------------------
  // classic up: counts up edges, saturates at the top, bit at >= preset.
  // classic down: counts to zero, a load restores the preset, bit at zero.
  // classic up/down: both directions, wraps at both ends, bit at >= preset.
  // standard up: counts until the preset is met, output at >= preset.
  // standard down: as classic down, but a load does not force the output.
  // standard up/down: halts at preset and at zero, one output for each.

  // ------------------------------------------------------------
  // elaboration check
  // ------------------------------------------------------------
  if (NUM_COUNTERS != ECB_NUM_COUNTERS) begin : g_bad_size
    $error("ecb_bank: counter numbering is fixed at 256");
  end

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  // per-counter value, bit and edge history, indexed by counter number
  logic [ECB_VAL_W-1:0] value_mem [NUM_COUNTERS];
  logic [NUM_COUNTERS-1:0] bit_mem;
  logic [NUM_COUNTERS-1:0] prev_up;
  logic [NUM_COUNTERS-1:0] prev_down;

  // first-scan sweep state
  logic                 sweeping;
  logic [ECB_IDX_W-1:0] sweep_idx;
  logic                 sweep_last;
  logic                 clear_values;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // signed compare; used for several types
  function automatic logic ecb_ge(input logic [15:0] a, input logic [15:0] b);
    ecb_ge = $signed(a) >= $signed(b);
  endfunction

  function automatic logic [15:0] ecb_inc(input logic [15:0] a);
    ecb_inc = a + 16'h0001;
  endfunction

  function automatic logic [15:0] ecb_dec(input logic [15:0] a);
    ecb_dec = a - 16'h0001;
  endfunction

  // zero test shared by the halting down directions and their outputs
  function automatic logic ecb_is_zero(input logic [15:0] a);
    ecb_is_zero = (a == ECB_ZERO_VAL);
  endfunction

  // ------------------------------------------------------------
  // evaluation, combinational
  // ------------------------------------------------------------
  // current request decoded into the next state of one counter
  logic [ECB_VAL_W-1:0] cur;
  logic                 up_edge;
  logic                 down_edge;
  logic [ECB_VAL_W-1:0] next_value;
  logic                 next_bit;
  logic                 next_qu;
  logic                 next_qd;
  logic                 eval;
  logic                 same_num;
  logic                 cmd_clear;

  // nothing is taken while reset is low, since the value array has no reset
  assign eval = exec & ~sweeping & nrst;
  // a reset instruction on the counter under evaluation gives way to it
  assign same_num  = (counter_num == reset_cmd_num);
  assign cmd_clear = reset_cmd & ~sweeping & nrst & ~(eval & same_num);
  assign cur  = value_mem[counter_num];
  // edge only against the level seen at this counter's last evaluation
  assign up_edge   = count_up_input & ~prev_up[counter_num];
  assign down_edge = count_down_input & ~prev_down[counter_num];

  // reset and load are tested first so a same-cycle edge is dropped
  always_comb begin
    next_value = cur;
    next_bit   = 1'b0;
    next_qu    = 1'b0;
    next_qd    = 1'b0;
    case (counter_type)
      ECB_CLS_UP_COUNTER_TYPE: begin
        // saturates rather than wraps; the bit follows the new value at once
        if (reset_input) begin
          next_value = ECB_ZERO_VAL;
        end else if (up_edge && cur != ECB_MAX_VAL) begin
          next_value = ecb_inc(cur);
        end
        next_bit = reset_input ? 1'b0 : ecb_ge(next_value, preset_value);
      end
      ECB_CLS_DOWN_COUNTER_TYPE: begin
        // a load forces the bit off for this evaluation, even with a zero preset
        if (load_preset_input) begin
          next_value = preset_value;
        end else if (down_edge && !ecb_is_zero(cur)) begin
          next_value = ecb_dec(cur);
        end
        next_bit = load_preset_input ? 1'b0 : ecb_is_zero(next_value);
      end
      ECB_CLS_UP_DOWN_COUNTER_TYPE: begin
        if (reset_input) begin
          next_value = ECB_ZERO_VAL;
        end else if (up_edge && !down_edge) begin
          next_value = ecb_inc(cur);
        end else if (down_edge && !up_edge) begin
          next_value = ecb_dec(cur);
        end
        // both edges together cancel; the wrap falls out of 16-bit math
        next_bit = reset_input ? 1'b0 : ecb_ge(next_value, preset_value);
      end
      ECB_STD_UP_COUNTER_TYPE: begin
        // halts once the preset is met, so a lowered preset freezes the count
        // the output is never forced low: it reads the new value
        if (reset_input) begin
          next_value = ECB_ZERO_VAL;
        end else if (up_edge && !ecb_ge(cur, preset_value)) begin
          next_value = ecb_inc(cur);
        end
        next_bit = ecb_ge(next_value, preset_value);
      end
      ECB_STD_DOWN_COUNTER_TYPE: begin
        // unlike the classic type, a load of zero leaves the output on
        if (load_preset_input) begin
          next_value = preset_value;
        end else if (down_edge && !ecb_is_zero(cur)) begin
          next_value = ecb_dec(cur);
        end
        next_bit = ecb_is_zero(next_value);
      end
      ECB_STD_UP_DOWN_COUNTER_TYPE: begin
        // reset beats load; both edges at once cancel as in the classic type
        if (reset_input) begin
          next_value = ECB_ZERO_VAL;
        end else if (load_preset_input) begin
          next_value = preset_value;
        end else if (up_edge && !down_edge && cur != preset_value) begin
          next_value = ecb_inc(cur);
        end else if (down_edge && !up_edge && !ecb_is_zero(cur)) begin
          next_value = ecb_dec(cur);
        end
        // exact equality: a count above the preset shows neither output
        next_qu  = (next_value == preset_value);
        next_qd  = ecb_is_zero(next_value);
        // counter_bit mirrors the up output for this type
        next_bit = next_qu;
      end
      default: begin
        // an undefined type leaves the counter as it is
        next_value = cur;
        next_bit   = bit_mem[counter_num];
      end
    endcase
  end

  // ------------------------------------------------------------
  // first-scan sweep
  // ------------------------------------------------------------
  // the last counter ends the sweep, so busy stands for 256 cycles
  assign sweep_last = (sweep_idx == ECB_IDX_LAST);

  // one counter per cycle; avoids a 256-wide clear of the value array
  // a first scan that arrives during a sweep is ignored, not queued
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sweeping     <= 1'b0;
      sweep_idx    <= ECB_IDX_ZERO;
      clear_values <= 1'b0;
    end else if (first_scan && !sweeping) begin
      sweeping     <= 1'b1;
      sweep_idx    <= ECB_IDX_ZERO;
      clear_values <= ~retentive_all;
    end else if (sweeping) begin
      sweep_idx <= sweep_idx + 8'h01;
      if (sweep_last) begin
        sweeping <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // value array
  // ------------------------------------------------------------
  // no reset on the array: values survive a controller reset when retentive
  always_ff @(posedge mclk) begin
    if (sweeping && clear_values) begin
      value_mem[sweep_idx] <= ECB_RESET_VAL;
    end else if (eval) begin
      value_mem[counter_num] <= next_value;
    end
    // a reset instruction during a sweep is lost, not held back for later
    if (cmd_clear) begin
      value_mem[reset_cmd_num] <= ECB_ZERO_VAL;
    end
  end

  // ------------------------------------------------------------
  // counter bits and sampled input levels
  // ------------------------------------------------------------
  // edge history survives a first scan: a level held high across it gives
  // no edge at the next evaluation
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      bit_mem   <= '0;
      prev_up   <= '0;
      prev_down <= '0;
    end else if (sweeping) begin
      bit_mem[sweep_idx] <= 1'b0;
    end else begin
      if (eval) begin
        bit_mem[counter_num]   <= next_bit;
        prev_up[counter_num]   <= count_up_input;
        prev_down[counter_num] <= count_down_input;
      end
      if (cmd_clear) begin
        bit_mem[reset_cmd_num] <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // evaluation results
  // ------------------------------------------------------------
  // done is a one-cycle pulse per taken evaluation
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      done <= 1'b0;
    end else begin
      done <= eval;
    end
  end

  // results hold between evaluations so a slow controller can read them late
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      current_value       <= ECB_RESET_VAL;
      counter_bit         <= 1'b0;
      up_reached_output   <= 1'b0;
      down_reached_output <= 1'b0;
    end else begin
      if (eval) begin
        current_value       <= next_value;
        counter_bit         <= next_bit;
        up_reached_output   <= next_qu;
        down_reached_output <= next_qd;
      end
    end
  end

  // ------------------------------------------------------------
  // readback by number
  // ------------------------------------------------------------
  // a write at the same edge shows up one cycle later
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      read_value <= ECB_RESET_VAL;
      read_bit   <= 1'b0;
    end else begin
      read_value <= value_mem[read_num];
      read_bit   <= bit_mem[read_num];
    end
  end

  // straight from the sweep flop, so it carries no decode glitch
  assign busy = sweeping;

endmodule

// *** dv/ecb_bank_sva.sv ***
// assertion checker watching the event counter bank ports
`timescale 1ns/1ps
module ecb_bank_sva
  import ecb_pkg::*;
(
  // clock and reset
  input wire logic                 mclk,
  input wire logic                 nrst,
  // request side
  input wire logic                 exec,
  input wire ecb_type_t            counter_type,
  input wire logic                 reset_input,
  input wire logic                 load_preset_input,
  input wire logic [ECB_VAL_W-1:0] preset_value,
  input wire logic                 first_scan,
  // result side
  input wire logic                 busy,
  input wire logic                 done,
  input wire logic [ECB_VAL_W-1:0] current_value,
  input wire logic                 counter_bit,
  input wire logic                 up_reached_output,
  input wire logic                 down_reached_output
);
  // ------------------------------------------------------------
  // request seen one edge earlier, which is what done reports on
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  ecb_type_t   ty;
  logic [15:0] pre;
  logic        rs;
  logic        lp;
  logic        ge;
  logic        cls_cmp;
  // capture the evaluated request every edge
  always_ff @(posedge mclk) begin
    ty  <= counter_type;
    pre <= preset_value;
    rs  <= reset_input;
    lp  <= load_preset_input;
  end
  // signed compare, the values are two's complement counts
  assign ge      = $signed(current_value) >= $signed(pre);
  assign cls_cmp = ty == ECB_CLS_UP_COUNTER_TYPE || ty == ECB_CLS_UP_DOWN_COUNTER_TYPE;

  chk_exec_gets_done: assert property (exec && !busy |=> done)
    else $error("evaluation without done");
  chk_busy_refuses: assert property (exec && busy |=> !done)
    else $error("evaluation taken during sweep");
  chk_cls_cmp_bit: assert property (done && cls_cmp && !rs |-> counter_bit == ge)
    else $error("classic counter bit off compare");
  chk_cls_reset_clr: assert property (done && cls_cmp && rs |-> !counter_bit && current_value == 0)
    else $error("classic reset left value or bit");
  chk_down_zero_bit: assert property (done && ty == ECB_CLS_DOWN_COUNTER_TYPE && !lp
      |-> counter_bit == (current_value == 0))
    else $error("down counter bit off zero");
  chk_down_load_copy: assert property (done && ty == ECB_CLS_DOWN_COUNTER_TYPE && lp
      |-> !counter_bit && current_value == pre)
    else $error("down load did not copy preset");
  chk_std_up_q: assert property (done && ty == ECB_STD_UP_COUNTER_TYPE |-> counter_bit == ge)
    else $error("standard up output wrong");
  chk_std_down_q: assert property (done && ty == ECB_STD_DOWN_COUNTER_TYPE
      |-> counter_bit == (current_value == 0))
    else $error("standard down output wrong");
  chk_std_ud_outs: assert property (done && ty == ECB_STD_UP_DOWN_COUNTER_TYPE
      |-> up_reached_output == (current_value == pre) && down_reached_output == (current_value == 0))
    else $error("standard up/down outputs wrong");
  chk_scan_sweep_busy: assert property (first_scan && !busy |=> busy [*8])
    else $error("first scan sweep not busy");
  cover property (done && ty == ECB_CLS_UP_DOWN_COUNTER_TYPE);
  cover property (done && up_reached_output);
  cover property (done && rs);
endmodule

bind ecb_bank ecb_bank_sva u_sva (.mclk(mclk), .nrst(nrst), .exec(exec),
  .counter_type(counter_type), .reset_input(reset_input), .load_preset_input(load_preset_input),
  .preset_value(preset_value), .first_scan(first_scan), .busy(busy), .done(done),
  .current_value(current_value), .counter_bit(counter_bit),
  .up_reached_output(up_reached_output), .down_reached_output(down_reached_output));

// *** dv/ecb_ctrl_model.sv ***
// controlling program model that drives the counter bank requests
`timescale 1ns/1ps
module ecb_ctrl_model
  import ecb_pkg::*;
(
  // clock
  input  wire logic  mclk,
  // evaluation request
  output logic       exec,
  output logic [7:0] counter_num,
  output ecb_type_t  counter_type,
  output logic       count_up_input,
  output logic       count_down_input,
  output logic       reset_input,
  output logic       load_preset_input,
  output logic [15:0] preset_value,
  // reset instruction and first scan
  output logic       reset_cmd,
  output logic [7:0] reset_cmd_num,
  output logic       first_scan,
  output logic       retentive_all
);
  // all requests idle from time zero
  initial begin
    {exec, counter_num, count_up_input, count_down_input, reset_input} = '0;
    {load_preset_input, preset_value, reset_cmd, reset_cmd_num, first_scan} = '0;
    retentive_all = 1'h0;
    counter_type  = ECB_CLS_UP_COUNTER_TYPE;
  end
  // levels stay after the strobe drops, so edges depend only on evaluations
  // one number serves one counter type; the bench shares a number on purpose
  // only where it preloads a value through the shared current value
  task automatic ev(input logic [7:0] n, input ecb_type_t t, input logic [3:0] f,
                    input logic [15:0] p);
    @(posedge mclk);
    counter_num  <= n;
    counter_type <= t;
    {count_up_input, count_down_input, reset_input, load_preset_input} <= f;
    preset_value <= p;
    exec         <= 1'h1;
    @(posedge mclk);
    exec <= 1'h0;
  endtask
  // first scan pulse; the sweep takes one cycle per counter, no polling
  task automatic scan(input logic keep);
    @(posedge mclk);
    first_scan    <= 1'h1;
    retentive_all <= keep;
    @(posedge mclk);
    first_scan <= 1'h0;
    repeat (ECB_NUM_COUNTERS + 2) @(posedge mclk);
  endtask
  // reset instruction aimed at one counter number
  task automatic rc(input logic [7:0] n);
    @(posedge mclk);
    reset_cmd     <= 1'h1;
    reset_cmd_num <= n;
    @(posedge mclk);
    reset_cmd <= 1'h0;
  endtask
endmodule

// *** dv/ecb_bank_tb.sv ***
// self-checking testbench for the event counter bank
`timescale 1ns/1ps
module ecb_bank_tb
  import ecb_pkg::*;
;
  // ------------------------------------------------------------
  // signals, clock and instances
  // ------------------------------------------------------------
  localparam ecb_type_t KU = ECB_CLS_UP_COUNTER_TYPE, KD = ECB_CLS_DOWN_COUNTER_TYPE;
  localparam ecb_type_t KUD = ECB_CLS_UP_DOWN_COUNTER_TYPE, SU = ECB_STD_UP_COUNTER_TYPE;
  localparam ecb_type_t SD = ECB_STD_DOWN_COUNTER_TYPE, SUD = ECB_STD_UP_DOWN_COUNTER_TYPE;
  logic mclk = 1'h0, nrst = 1'h0, exec, count_up_input, count_down_input, reset_input;
  logic load_preset_input, reset_cmd, first_scan, retentive_all, read_bit, done, busy;
  logic counter_bit, up_reached_output, down_reached_output;
  logic [7:0] counter_num, reset_cmd_num, read_num = 8'h00;
  logic [15:0] preset_value, read_value, current_value;
  ecb_type_t counter_type;
  int mismatches = 0, n_tests = 0;
  always #4 mclk = ~mclk;
  ecb_bank DUT (.mclk, .nrst, .exec, .counter_num, .counter_type, .count_up_input,
    .count_down_input, .reset_input, .load_preset_input, .preset_value, .reset_cmd,
    .reset_cmd_num, .first_scan, .retentive_all, .read_num, .read_value, .read_bit, .done,
    .current_value, .counter_bit, .up_reached_output, .down_reached_output, .busy);
  ecb_ctrl_model CTRL (.mclk, .exec, .counter_num, .counter_type, .count_up_input,
    .count_down_input, .reset_input, .load_preset_input, .preset_value, .reset_cmd,
    .reset_cmd_num, .first_scan, .retentive_all);
  // compare tasks, one for values and one for flags
  task automatic chkv(input logic [15:0] a, input logic [15:0] x);
    n_tests++;
    if (a !== x) begin
      mismatches++;
      $display("wrong value at %0t: value %h want %h", $time, a, x);
    end
  endtask
  task automatic chkf(input logic [3:0] a, input logic [3:0] x);
    n_tests++;
    if (a !== x) begin
      mismatches++;
      $display("wrong value at %0t: flags %b want %b", $time, a, x);
    end
  endtask
  // one evaluation; flags o = bit, up output, down output
  task automatic e(input logic [7:0] n, input ecb_type_t t, input logic [3:0] f,
                   input logic [15:0] p, input logic [15:0] v, input logic [2:0] o);
    logic [3:0] m;
    m = (t == SU || t == SD) ? 4'hC : 4'hF; // these types leave up/down outputs open
    CTRL.ev(n, t, f, p);
    #1;
    chkf({done, counter_bit, up_reached_output, down_reached_output} & m, {1'h1, o} & m);
    chkv(current_value, v);
  endtask
  // same, after an evaluation with all levels low so that an edge follows
  task automatic eg(input logic [7:0] n, input ecb_type_t t, input logic [3:0] f,
                    input logic [15:0] p, input logic [15:0] v, input logic [2:0] o);
    CTRL.ev(n, t, 4'h0, p);
    e(n, t, f, p, v, o);
  endtask
  task automatic rd(input logic [7:0] n, input logic [15:0] v, input logic b);
    @(posedge mclk);
    read_num <= n;
    @(posedge mclk);
    #1;
    chkv(read_value, v);
    chkf({3'h0, read_bit}, {3'h0, b});
  endtask
  // classic up, saturation seeded by a load on the same number, then classic up/down wrap
  task automatic t_cls();
    eg(8'h01, KU, 4'h8, 16'h0002, 16'h0001, 3'h0);
    e(8'h01, KU, 4'h8, 16'h0002, 16'h0001, 3'h0);
    eg(8'h01, KU, 4'h8, 16'h0002, 16'h0002, 3'h4);
    e(8'h01, KU, 4'h2, 16'h0002, 16'h0000, 3'h0);
    e(8'h04, SUD, 4'h1, 16'h7FFF, 16'h7FFF, 3'h6);
    e(8'h04, KU, 4'h8, 16'h7FFF, 16'h7FFF, 3'h4);
    eg(8'h04, KU, 4'hA, 16'h7FFF, 16'h0000, 3'h0);
    e(8'h03, SUD, 4'h1, 16'h7FFF, 16'h7FFF, 3'h6);
    e(8'h03, KUD, 4'h8, 16'h0000, 16'h8000, 3'h0);
    e(8'h03, KUD, 4'h4, 16'h0000, 16'h7FFF, 3'h4);
    eg(8'h03, KUD, 4'h4, 16'h7FFF, 16'h7FFE, 3'h0);
    $display("test classic up and up/down done");
  endtask
  task automatic t_down();
    e(8'h05, KD, 4'h5, 16'h0002, 16'h0002, 3'h0);
    eg(8'h05, KD, 4'h4, 16'h0002, 16'h0001, 3'h0);
    eg(8'h05, KD, 4'h4, 16'h0002, 16'h0000, 3'h4);
    eg(8'h05, KD, 4'h4, 16'h0002, 16'h0000, 3'h4);
    $display("test classic down done");
  endtask
  task automatic t_std();
    eg(8'h06, SU, 4'h8, 16'h0002, 16'h0001, 3'h0);
    eg(8'h06, SU, 4'h8, 16'h0002, 16'h0002, 3'h4);
    eg(8'h06, SU, 4'h8, 16'h0002, 16'h0002, 3'h4);
    e(8'h06, SU, 4'h2, 16'h0002, 16'h0000, 3'h0);
    e(8'h07, SD, 4'h1, 16'h0001, 16'h0001, 3'h0);
    eg(8'h07, SD, 4'h4, 16'h0001, 16'h0000, 3'h4);
    eg(8'h07, SD, 4'h4, 16'h0001, 16'h0000, 3'h4);
    eg(8'h08, SUD, 4'h8, 16'h0002, 16'h0001, 3'h0);
    eg(8'h08, SUD, 4'h8, 16'h0002, 16'h0002, 3'h6);
    eg(8'h08, SUD, 4'h8, 16'h0002, 16'h0002, 3'h6);
    e(8'h08, SUD, 4'h2, 16'h0002, 16'h0000, 3'h1);
    eg(8'h08, SUD, 4'h4, 16'h0002, 16'h0000, 3'h1);
    $display("test standard types done");
  endtask
  // readback by number, reset instruction and both first-scan flavours
  task automatic t_bank();
    eg(8'hFF, KU, 4'h8, 16'h0001, 16'h0001, 3'h4);
    rd(8'hFF, 16'h0001, 1'h1);
    CTRL.rc(8'hFF);
    rd(8'hFF, 16'h0000, 1'h0);
    // retentive scan; a reset evaluation of counter 3 mid-sweep must be dropped
    fork
      CTRL.scan(1'h1);
      begin
        repeat (4) @(posedge mclk);
        CTRL.ev(8'h03, KUD, 4'h2, 16'h0001);
        #1;
        chkf({2'h0, busy, done}, 4'h2);
      end
    join
    rd(8'h05, 16'h0000, 1'h0);
    rd(8'h03, 16'h7FFE, 1'h0);
    CTRL.scan(1'h0);
    rd(8'h03, 16'h0000, 1'h0);
    $display("test bank readback and first scan done");
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // run takes about nine hundred cycles; the watchdog allows far more
  initial begin
    #50000;
    mismatches++;
    end_of_test();
  end
  initial begin
    repeat (8) @(posedge mclk);
    nrst <= 1'h1;
    CTRL.scan(1'h0);
    t_cls();
    t_down();
    t_std();
    t_bank();
    end_of_test();
  end
endmodule
